// >>> verilog/radio_service_pkg.sv
// package: register map, field layout and types of the radio service registers
`default_nettype none
package radio_service_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] ADDR_CAL   = 8'h3B;
	localparam logic [7:0] ADDR_TEMP  = 8'h3C;
	localparam logic [7:0] ADDR_BAT   = 8'h3D;
	localparam logic [7:0] ADDR_FLG1  = 8'h3E;
	localparam logic [7:0] ADDR_FLG2  = 8'h3F;
	// calibration register fields
	localparam int CAL_AUTO_BIT    = 7;
	localparam int CAL_START_BIT   = 6;
	localparam int CAL_RUN_BIT     = 5;
	localparam int CAL_TCHG_BIT    = 3;
	localparam int CAL_THR_LSB     = 1;
	localparam int CAL_MONSTOP_BIT = 0;
	localparam logic [1:0] CAL_THR_RESET = 2'h1;
	// battery register fields
	localparam int BAT_EN_BIT = 3;
	localparam logic [2:0] BAT_TRIM_RESET = 3'h2;
	// flag register 1
	localparam int F1_MODE_RDY = 7;
	localparam int F1_RX_RDY   = 6;
	localparam int F1_TX_RDY   = 5;
	localparam int F1_LOCK     = 4;
	localparam int F1_RSSI     = 3;
	localparam int F1_TIMEOUT  = 2;
	localparam int F1_PREAMBLE = 1;
	localparam int F1_SYNC     = 0;
	// flag register 2
	localparam int F2_FULL     = 7;
	localparam int F2_EMPTY    = 6;
	localparam int F2_LEVEL    = 5;
	localparam int F2_OVERRUN  = 4;
	localparam int F2_SENT     = 3;
	localparam int F2_PAYLOAD  = 2;
	localparam int F2_CRC_OK   = 1;
	localparam int F2_BAT_LOW  = 0;
	// fifo
	localparam logic [6:0] FIFO_FULL_COUNT = 7'h42;
	// threshold step of temperature change
	localparam logic [7:0] TEMP_STEP = 8'h05;

	typedef enum logic [2:0] {
		MODE_SLEEP   = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_SYNTH   = 3'b010,
		MODE_TX      = 3'b011,
		MODE_RX      = 3'b100
	} op_mode_type;

	// events from radio core
	typedef struct packed {
		logic mode_reached;
		logic rx_chain_done;
		logic pa_ramp_done;
		logic pll_locked;
		logic rx_timeout;
		logic preamble_found;
		logic sync_found;
		logic fifo_overrun;
		logic packet_done;
		logic payload_done;
		logic checksum_ok;
		logic crc_enable;
		logic checksum_autoclear_disable;
		logic battery_below;
		logic continuous_mode;
		logic cal_done;
	} radio_event_type;
endpackage
`default_nettype wire

// >>> verilog/radio_service_irq_flag_regs.sv
// radio service and flag registers on an ahb-lite slave
// Operation
// - auto calibration enable allows temperature recalibration
// - start trigger in standby launches calibration
// - running flag high during calibration
// - change flag when drift exceeds threshold
// - threshold codes select 5 to 20 C
// - monitor stop halts temperature monitoring
// - read-only measured temperature register
// - battery detector enable, reset zero
// - battery trim field, reset code 010
// - mode ready set on reach, cleared on change
// - rx and tx ready per mode
// - lock flag follows pll in active modes
// - rssi flag set in rx, w1c
// - timeout flag cleared leaving rx or empty
// - preamble flag set on detect, w1c
// - sync flag; w1c only in continuous
// - full at 66 bytes, empty at zero
// - level flag when count exceeds threshold
// - overrun flag; writing one flushes fifo
// - packet sent set in tx, cleared leaving
// - payload ready and crc good flags
// - battery low flag cleared only by w1c
`timescale 1ns/10ps
`default_nettype none
module radio_service_irq_flag_regs (
	// ahb-lite
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// radio core status
	input  wire radio_service_pkg::op_mode_type     op_mode,
	input  wire radio_service_pkg::radio_event_type radio_event,
	input  wire logic [7:0]  sensor_temperature,
	input  wire logic [6:0]  fifo_count,
	input  wire logic [6:0]  buffer_level_threshold,
	input  wire logic [7:0]  signal_strength_value,
	input  wire logic [7:0]  signal_strength_threshold,
	// controls to radio core
	output logic             calibration_request,
	output logic             temperature_monitor_run,
	output logic             battery_detector_enable,
	output logic      [2:0]  battery_threshold_trim,
	output logic             fifo_flush
);
	// bus pipeline
	logic       wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic       rd_go;
	logic       wr_go;
	logic [7:0] wdat;
	// cal register
	logic       auto_calibration_enable_ff;
	logic       calibration_running_flag_ff;
	logic [1:0] temperature_change_threshold_ff;
	logic       temperature_monitor_stop_ff;
	logic [7:0] measured_temperature_ff;
	logic [7:0] cal_temperature_ff;
	logic       temperature_change_flag;
	logic [7:0] drift;
	logic [7:0] thr_deg;
	// flags
	radio_service_pkg::op_mode_type mode_prev_ff;
	logic        mode_ready_flag_ff;
	logic        receive_ready_flag_ff;
	logic        transmit_ready_flag_ff;
	logic        synth_lock_flag_ff;
	logic        rssi_flag_ff;
	logic        timeout_flag_ff;
	logic        preamble_found_flag_ff;
	logic        sync_match_flag_ff;
	logic        buffer_overrun_flag_ff;
	logic        packet_sent_flag_ff;
	logic        payload_ready_flag_ff;
	logic        checksum_good_flag_ff;
	logic        battery_low_flag_ff;
	logic        in_rx;
	logic        left_rx;
	logic        left_tx;
	logic        mode_changed;
	logic        fifo_empty;
	logic        w1c1;
	logic        w1c2;
	logic [7:0]  nxt_rdata;

	function automatic logic clr_bit(input logic sel, input logic [7:0] d,
	                                 input int b);
		clr_bit = sel & d[b];
	endfunction

	assign rd_go = hsel & hready & htrans[1] & ~hwrite;
	assign wr_go = wr_pend_ff;
	assign wdat  = hwdata[7:0];
	assign w1c1  = wr_go & (wr_addr_ff == radio_service_pkg::ADDR_FLG1);
	assign w1c2  = wr_go & (wr_addr_ff == radio_service_pkg::ADDR_FLG2);

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= hsel & hready & htrans[1] & hwrite;
			wr_addr_ff <= haddr[9:2];
		end
	end

	// cal and battery control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_calibration_enable_ff      <= 1'b0;
			temperature_change_threshold_ff <=
				radio_service_pkg::CAL_THR_RESET;
			temperature_monitor_stop_ff     <= 1'b0;
			battery_detector_enable         <= 1'b0;
			battery_threshold_trim          <=
				radio_service_pkg::BAT_TRIM_RESET;
		end else if (wr_go) begin
			if (wr_addr_ff == radio_service_pkg::ADDR_CAL) begin
				auto_calibration_enable_ff <=
					wdat[radio_service_pkg::CAL_AUTO_BIT];
				temperature_change_threshold_ff <=
					wdat[radio_service_pkg::CAL_THR_LSB +: 2];
				temperature_monitor_stop_ff <=
					wdat[radio_service_pkg::CAL_MONSTOP_BIT];
			end
			if (wr_addr_ff == radio_service_pkg::ADDR_BAT) begin
				battery_detector_enable <=
					wdat[radio_service_pkg::BAT_EN_BIT];
				battery_threshold_trim  <= wdat[2:0];
			end
		end
	end

	// temperature drift against last calibration
	assign thr_deg = radio_service_pkg::TEMP_STEP *
		({6'h00, temperature_change_threshold_ff} + 8'h01);
	assign drift = (measured_temperature_ff >= cal_temperature_ff) ?
		measured_temperature_ff - cal_temperature_ff :
		cal_temperature_ff - measured_temperature_ff;
	assign temperature_change_flag = drift > thr_deg;

	// calibration sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			calibration_running_flag_ff <= 1'b0;
			calibration_request         <= 1'b0;
			cal_temperature_ff          <= 8'h00;
		end else begin
			calibration_request <= 1'b0;
			if (calibration_running_flag_ff) begin
				if (radio_event.cal_done) begin
					calibration_running_flag_ff <= 1'b0;
					cal_temperature_ff <= measured_temperature_ff;
				end
			end else if (wr_go &&
			             wr_addr_ff == radio_service_pkg::ADDR_CAL &&
			             wdat[radio_service_pkg::CAL_START_BIT] &&
			             op_mode == radio_service_pkg::MODE_STANDBY) begin
				calibration_running_flag_ff <= 1'b1;
				calibration_request         <= 1'b1;
			end else if (auto_calibration_enable_ff &&
			             temperature_change_flag &&
			             temperature_monitor_run) begin
				calibration_running_flag_ff <= 1'b1;
				calibration_request         <= 1'b1;
			end
		end
	end

	// temperature monitor
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temperature_monitor_run <= 1'b0;
			measured_temperature_ff <= 8'h00;
		end else begin
			temperature_monitor_run <= ~temperature_monitor_stop_ff &
				(op_mode != radio_service_pkg::MODE_SLEEP) &
				(op_mode != radio_service_pkg::MODE_STANDBY);
			if (temperature_monitor_run)
				measured_temperature_ff <= sensor_temperature;
		end
	end

	assign in_rx        = op_mode == radio_service_pkg::MODE_RX;
	assign mode_changed = op_mode != mode_prev_ff;
	assign left_rx = mode_changed & (mode_prev_ff == radio_service_pkg::MODE_RX);
	assign left_tx = mode_changed & (mode_prev_ff == radio_service_pkg::MODE_TX);
	assign fifo_empty = fifo_count == 7'h00;

	// mode related flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_prev_ff           <= radio_service_pkg::MODE_SLEEP;
			mode_ready_flag_ff     <= 1'b0;
			receive_ready_flag_ff  <= 1'b0;
			transmit_ready_flag_ff <= 1'b0;
			synth_lock_flag_ff     <= 1'b0;
		end else begin
			mode_prev_ff <= op_mode;
			if (mode_changed)
				mode_ready_flag_ff <= 1'b0;
			else if (radio_event.mode_reached)
				mode_ready_flag_ff <= 1'b1;
			if (!in_rx)
				receive_ready_flag_ff <= 1'b0;
			else if (radio_event.rx_chain_done)
				receive_ready_flag_ff <= 1'b1;
			if (op_mode != radio_service_pkg::MODE_TX)
				transmit_ready_flag_ff <= 1'b0;
			else if (radio_event.pa_ramp_done)
				transmit_ready_flag_ff <= 1'b1;
			synth_lock_flag_ff <= radio_event.pll_locked &
				(op_mode == radio_service_pkg::MODE_SYNTH ||
				 op_mode == radio_service_pkg::MODE_TX || in_rx);
		end
	end

	// receive event flags, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rssi_flag_ff           <= 1'b0;
			timeout_flag_ff        <= 1'b0;
			preamble_found_flag_ff <= 1'b0;
			sync_match_flag_ff     <= 1'b0;
		end else begin
			if (in_rx && signal_strength_value > signal_strength_threshold)
				rssi_flag_ff <= 1'b1;
			else if (left_rx ||
			         clr_bit(w1c1, wdat, radio_service_pkg::F1_RSSI))
				rssi_flag_ff <= 1'b0;
			if (radio_event.rx_timeout)
				timeout_flag_ff <= 1'b1;
			else if (left_rx || fifo_empty)
				timeout_flag_ff <= 1'b0;
			if (radio_event.preamble_found)
				preamble_found_flag_ff <= 1'b1;
			else if (clr_bit(w1c1, wdat, radio_service_pkg::F1_PREAMBLE))
				preamble_found_flag_ff <= 1'b0;
			if (radio_event.sync_found)
				sync_match_flag_ff <= 1'b1;
			else if (left_rx || fifo_empty ||
			         (radio_event.continuous_mode &&
			          clr_bit(w1c1, wdat, radio_service_pkg::F1_SYNC)))
				sync_match_flag_ff <= 1'b0;
		end
	end

	// fifo and packet flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buffer_overrun_flag_ff <= 1'b0;
			packet_sent_flag_ff    <= 1'b0;
			payload_ready_flag_ff  <= 1'b0;
			checksum_good_flag_ff  <= 1'b0;
			battery_low_flag_ff    <= 1'b0;
			fifo_flush             <= 1'b0;
		end else begin
			fifo_flush <= clr_bit(w1c2, wdat,
				radio_service_pkg::F2_OVERRUN);
			if (radio_event.fifo_overrun &&
			    op_mode != radio_service_pkg::MODE_SLEEP)
				buffer_overrun_flag_ff <= 1'b1;
			else if (clr_bit(w1c2, wdat, radio_service_pkg::F2_OVERRUN))
				buffer_overrun_flag_ff <= 1'b0;
			if (radio_event.packet_done &&
			    op_mode == radio_service_pkg::MODE_TX)
				packet_sent_flag_ff <= 1'b1;
			else if (left_tx)
				packet_sent_flag_ff <= 1'b0;
			if (in_rx && radio_event.payload_done &&
			    (!radio_event.crc_enable ||
			     radio_event.checksum_autoclear_disable ||
			     radio_event.checksum_ok))
				payload_ready_flag_ff <= 1'b1;
			else if (fifo_empty)
				payload_ready_flag_ff <= 1'b0;
			if (in_rx && radio_event.checksum_ok)
				checksum_good_flag_ff <= 1'b1;
			else if (fifo_empty)
				checksum_good_flag_ff <= 1'b0;
			if (radio_event.battery_below && battery_detector_enable)
				battery_low_flag_ff <= 1'b1;
			else if (clr_bit(w1c2, wdat, radio_service_pkg::F2_BAT_LOW))
				battery_low_flag_ff <= 1'b0;
		end
	end

	// read mux, registered so data meets the data phase
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (haddr[9:2])
			radio_service_pkg::ADDR_CAL:
				nxt_rdata = {auto_calibration_enable_ff, 1'b0,
					calibration_running_flag_ff, 1'b0,
					temperature_change_flag,
					temperature_change_threshold_ff,
					temperature_monitor_stop_ff};
			radio_service_pkg::ADDR_TEMP:
				nxt_rdata = measured_temperature_ff;
			radio_service_pkg::ADDR_BAT:
				nxt_rdata = {4'h0, battery_detector_enable,
					battery_threshold_trim};
			radio_service_pkg::ADDR_FLG1:
				nxt_rdata = {mode_ready_flag_ff, receive_ready_flag_ff,
					transmit_ready_flag_ff, synth_lock_flag_ff,
					rssi_flag_ff, timeout_flag_ff,
					preamble_found_flag_ff, sync_match_flag_ff};
			radio_service_pkg::ADDR_FLG2:
				nxt_rdata = {fifo_count == radio_service_pkg::FIFO_FULL_COUNT,
					fifo_empty, fifo_count > buffer_level_threshold,
					buffer_overrun_flag_ff, packet_sent_flag_ff,
					payload_ready_flag_ff, checksum_good_flag_ff,
					battery_low_flag_ff};
			default:
				nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_go)
				hrdata <= {24'h000000, nxt_rdata};
		end
	end
endmodule
`default_nettype wire

// >>> bench/radio_service_chk.sv
// port checker of the radio service register block
`timescale 1ns/10ps
`default_nettype none
module radio_service_chk (
	// ahb-lite
	input wire logic                                hclk,
	input wire logic                                hresetn,
	input wire logic                                hsel,
	input wire logic [31:0]                         haddr,
	input wire logic [1:0]                          htrans,
	input wire logic                                hwrite,
	input wire logic [31:0]                         hwdata,
	input wire logic                                hready,
	input wire logic [31:0]                         hrdata,
	// radio core
	input wire radio_service_pkg::op_mode_type      op_mode,
	input wire logic [7:0]                          sensor_temperature,
	input wire logic                                calibration_request,
	input wire logic                                temperature_monitor_run,
	input wire logic                                battery_detector_enable,
	input wire logic [2:0]                          battery_threshold_trim,
	input wire logic                                fifo_flush
);
	logic       take;
	logic       dph_wr_ff;
	logic       dph_rd_ff;
	logic [7:0] dph_idx_ff;
	logic [7:0] temp_ref_ff;
	assign take = hsel & hready & htrans[1];
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_ff  <= 1'b0;
			dph_rd_ff  <= 1'b0;
			dph_idx_ff <= 8'h00;
		end else begin
			dph_wr_ff  <= take & hwrite;
			dph_rd_ff  <= take & ~hwrite;
			dph_idx_ff <= haddr[9:2];
		end
	end
	// temperature seen while the monitor runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			temp_ref_ff <= 8'h00;
		else if (temperature_monitor_run)
			temp_ref_ff <= sensor_temperature;
	end
	sequence s_cal_start;
		take && hwrite && haddr[9:2] == radio_service_pkg::ADDR_CAL ##1
		hwdata[6] && op_mode == radio_service_pkg::MODE_STANDBY;
	endsequence
	sequence s_ovr_clear;
		take && hwrite && haddr[9:2] == radio_service_pkg::ADDR_FLG2 ##1
		hwdata[4];
	endsequence
	property p_cal_start;
		s_cal_start |=> calibration_request;
	endproperty
	property p_cal_pulse;
		calibration_request |=> !calibration_request;
	endproperty
	property p_flush;
		s_ovr_clear |=> fifo_flush;
	endproperty
	property p_flush_cause;
		fifo_flush |-> $past(dph_wr_ff && hwdata[4] &&
			dph_idx_ff == radio_service_pkg::ADDR_FLG2);
	endproperty
	property p_bat_write;
		dph_wr_ff && dph_idx_ff == radio_service_pkg::ADDR_BAT |=>
			battery_detector_enable == $past(hwdata[3]) &&
			battery_threshold_trim == $past(hwdata[2:0]);
	endproperty
	property p_bat_hold;
		!(dph_wr_ff && dph_idx_ff == radio_service_pkg::ADDR_BAT) |=>
			$stable(battery_detector_enable) && $stable(battery_threshold_trim);
	endproperty
	property p_temp_read;
		dph_rd_ff && dph_idx_ff == radio_service_pkg::ADDR_TEMP |->
			hrdata == {24'h000000, $past(temp_ref_ff)};
	endproperty
	property p_monitor_idle;
		op_mode == radio_service_pkg::MODE_SLEEP ||
			op_mode == radio_service_pkg::MODE_STANDBY |=>
			!temperature_monitor_run;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("no cal request");
	a_cal_pulse: assert property (p_cal_pulse) else $error("cal request long");
	a_flush: assert property (p_flush) else $error("no fifo flush");
	a_flush_cause: assert property (p_flush_cause) else $error("stray flush");
	a_bat_write: assert property (p_bat_write) else $error("bat field bad");
	a_bat_hold: assert property (p_bat_hold) else $error("bat field moved");
	a_temp_read: assert property (p_temp_read) else $error("temp read bad");
	a_monitor_idle: assert property (p_monitor_idle) else $error("monitor on");
endmodule
bind radio_service_irq_flag_regs radio_service_chk radio_service_chk_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .op_mode(op_mode),
	.sensor_temperature(sensor_temperature),
	.calibration_request(calibration_request),
	.temperature_monitor_run(temperature_monitor_run),
	.battery_detector_enable(battery_detector_enable),
	.battery_threshold_trim(battery_threshold_trim),
	.fifo_flush(fifo_flush)
);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the radio service register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                                hclk;
	logic                                hresetn;
	logic                                hsel;
	logic [31:0]                         haddr;
	logic [1:0]                          htrans;
	logic                                hwrite;
	logic [2:0]                          hsize;
	logic [31:0]                         hwdata;
	logic                                hready;
	logic [31:0]                         hrdata;
	logic                                hreadyout;
	logic                                hresp;
	radio_service_pkg::op_mode_type      op_mode;
	radio_service_pkg::radio_event_type  radio_event;
	radio_service_pkg::radio_event_type  e;
	logic [7:0]                          sensor_temperature;
	logic [6:0]                          fifo_count;
	logic [6:0]                          buffer_level_threshold;
	logic [7:0]                          signal_strength_value;
	logic [7:0]                          signal_strength_threshold;
	logic                                calibration_request;
	logic                                temperature_monitor_run;
	logic                                battery_detector_enable;
	logic [2:0]                          battery_threshold_trim;
	logic                                fifo_flush;
	logic [7:0]                          rd;
	int                                  n_fail;
	int                                  cmp_count;
	assign hready = hreadyout;
	radio_service_irq_flag_regs radio_service_irq_flag_regs_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .op_mode(op_mode), .radio_event(radio_event),
		.sensor_temperature(sensor_temperature), .fifo_count(fifo_count),
		.buffer_level_threshold(buffer_level_threshold),
		.signal_strength_value(signal_strength_value),
		.signal_strength_threshold(signal_strength_threshold),
		.calibration_request(calibration_request),
		.temperature_monitor_run(temperature_monitor_run),
		.battery_detector_enable(battery_detector_enable),
		.battery_threshold_trim(battery_threshold_trim),
		.fifo_flush(fifo_flush)
	);
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task print_verdict;
		if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		cmp_count++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// one edge, then until hready, bounded
	task wt;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 16);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			print_verdict;
		end
	endtask
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h000000, idx, 2'h0};
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wt;
		rd = hrdata[7:0];
	endtask
	task rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] ex,
			input string nm);
		bus(1'b0, idx, 8'h00);
		chk(nm, ex, rd & m);
	endtask
	task pulse;
		radio_event <= e;
		@(posedge hclk);
		radio_event <= '0;
		@(posedge hclk);
		e = '0;
	endtask
	// catch a one-cycle output pulse within four edges
	task seen(input int k, input string nm);
		int i;
		logic h;
		h = 1'b0;
		for (i = 0; i < 4; i++) begin
			#1;
			h = h | (k == 1 ? fifo_flush : calibration_request);
			@(posedge hclk);
		end
		@(posedge hclk);
		chk(nm, 8'h01, {7'h00, h});
	endtask
	task t_reset;
		rdc(radio_service_pkg::ADDR_CAL, 8'hFF, 8'h02, "cal reset");
		rdc(radio_service_pkg::ADDR_BAT, 8'hFF, 8'h02, "bat reset");
		chk("bat out", 8'h02, {4'h0, battery_detector_enable, battery_threshold_trim});
	endtask
	task t_regs;
		bus(1'b1, radio_service_pkg::ADDR_BAT, 8'hFF);
		rdc(radio_service_pkg::ADDR_BAT, 8'hFF, 8'h0F, "bat rw");
		chk("bat out", 8'h0F, {4'h0, battery_detector_enable, battery_threshold_trim});
		op_mode <= radio_service_pkg::MODE_SYNTH;
		sensor_temperature <= 8'hA5;
		bus(1'b1, radio_service_pkg::ADDR_TEMP, 8'h00);
		rdc(radio_service_pkg::ADDR_TEMP, 8'hFF, 8'hA5, "temp");
		bus(1'b1, 8'h30, 8'hFF);
		rdc(8'h30, 8'hFF, 8'h00, "unmapped");
		chk("resp", 8'h00, {7'h00, hresp});
	endtask
	task t_fifo;
		logic [6:0] cnt [6];
		int i;
		cnt = '{7'd0, 7'd1, 7'd10, 7'd11, 7'd65, 7'd66};
		buffer_level_threshold <= 7'd10;
		for (i = 0; i < 6; i++) begin
			fifo_count <= cnt[i];
			repeat (2) @(posedge hclk);
			rdc(radio_service_pkg::ADDR_FLG2, 8'hE0, {cnt[i] == 7'd66,
				cnt[i] == 7'd0, cnt[i] > 7'd10, 5'h00}, "fifo");
		end
	endtask
	task t_w1c;
		e.preamble_found = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG1, 8'h02, 8'h02, "pre set");
		bus(1'b1, radio_service_pkg::ADDR_FLG1, 8'h00);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h02, 8'h02, "pre w0");
		bus(1'b1, radio_service_pkg::ADDR_FLG1, 8'h02);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h02, 8'h00, "pre w1");
		op_mode <= radio_service_pkg::MODE_STANDBY;
		e.fifo_overrun = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG2, 8'h10, 8'h10, "ovr set");
		bus(1'b1, radio_service_pkg::ADDR_FLG2, 8'h10);
		seen(1, "flush");
		rdc(radio_service_pkg::ADDR_FLG2, 8'h10, 8'h00, "ovr clr");
		e.battery_below = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG2, 8'h01, 8'h01, "bat low");
		bus(1'b1, radio_service_pkg::ADDR_FLG2, 8'h01);
		rdc(radio_service_pkg::ADDR_FLG2, 8'h01, 8'h00, "bat clr");
	endtask
	task t_cal;
		bus(1'b1, radio_service_pkg::ADDR_CAL, 8'h42);
		seen(0, "cal req");
		rdc(radio_service_pkg::ADDR_CAL, 8'h20, 8'h20, "cal run");
		e.cal_done = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_CAL, 8'h20, 8'h00, "cal done");
	endtask
	task t_rx;
		op_mode <= radio_service_pkg::MODE_RX;
		signal_strength_threshold <= 8'h40;
		signal_strength_value <= 8'h80;
		radio_event.pll_locked <= 1'b1;
		repeat (3) @(posedge hclk);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h18, 8'h18, "rssi lock");
		chk("mon run", 8'h01, {7'h00, temperature_monitor_run});
		signal_strength_value <= 8'h10;
		bus(1'b1, radio_service_pkg::ADDR_FLG1, 8'h08);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h08, 8'h00, "rssi clr");
		bus(1'b1, radio_service_pkg::ADDR_CAL, 8'h03);
		repeat (2) @(posedge hclk);
		chk("mon stop", 8'h00, {7'h00, temperature_monitor_run});
		e.mode_reached = 1'b1;
		e.pll_locked = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG1, 8'h90, 8'h80, "rdy unlock");
		op_mode <= radio_service_pkg::MODE_STANDBY;
		repeat (2) @(posedge hclk);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h80, 8'h00, "rdy clr");
	endtask
	task t_auto;
		op_mode <= radio_service_pkg::MODE_RX;
		sensor_temperature <= 8'hAB;
		bus(1'b1, radio_service_pkg::ADDR_CAL, 8'h00);
		repeat (3) @(posedge hclk);
		rdc(radio_service_pkg::ADDR_CAL, 8'h28, 8'h08, "drift");
		bus(1'b1, radio_service_pkg::ADDR_CAL, 8'h80);
		seen(0, "auto req");
		e.cal_done = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_CAL, 8'h28, 8'h00, "recal");
	endtask
	task t_flags;
		e.rx_chain_done = 1'b1;
		e.rx_timeout = 1'b1;
		e.sync_found = 1'b1;
		e.payload_done = 1'b1;
		e.checksum_ok = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG1, 8'h45, 8'h45, "rxf");
		rdc(radio_service_pkg::ADDR_FLG2, 8'h06, 8'h06, "pay");
		bus(1'b1, radio_service_pkg::ADDR_FLG1, 8'h01);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h01, 8'h01, "sync ro");
		fifo_count <= 7'h00;
		repeat (2) @(posedge hclk);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h05, 8'h00, "empty1");
		rdc(radio_service_pkg::ADDR_FLG2, 8'h06, 8'h00, "empty2");
		op_mode <= radio_service_pkg::MODE_TX;
		e.pa_ramp_done = 1'b1;
		e.packet_done = 1'b1;
		pulse;
		rdc(radio_service_pkg::ADDR_FLG1, 8'h60, 8'h20, "txrdy");
		rdc(radio_service_pkg::ADDR_FLG2, 8'h08, 8'h08, "sent");
		op_mode <= radio_service_pkg::MODE_STANDBY;
		repeat (2) @(posedge hclk);
		rdc(radio_service_pkg::ADDR_FLG1, 8'h20, 8'h00, "txleft");
		rdc(radio_service_pkg::ADDR_FLG2, 8'h08, 8'h00, "sentclr");
	endtask
	initial begin
		n_fail = 0;
		cmp_count = 0;
		e = '0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		op_mode = radio_service_pkg::MODE_SLEEP;
		radio_event = '0;
		sensor_temperature = 8'h00;
		fifo_count = 7'h00;
		buffer_level_threshold = 7'h0A;
		signal_strength_value = 8'h00;
		signal_strength_threshold = 8'hFF;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_regs;
		t_fifo;
		t_w1c;
		t_cal;
		t_rx;
		t_auto;
		t_flags;
		print_verdict;
	end
endmodule
`default_nettype wire
